// ### hw/adc_ctrl_pkg.sv
package adc_ctrl_pkg;

  // ****************************************
  // register location and bit fields
  // ****************************************
  localparam logic [7:0] CTRL_ADDR = 8'hE8;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int BIT_ENABLE = 7;
  localparam int BIT_TRACK_MODE = 6;
  localparam int BIT_DONE = 5;
  localparam int BIT_BUSY = 4;
  localparam int BIT_WINDOW = 3;
  localparam int SRC_MSB = 2;
  localparam int SRC_LSB = 0;

  // ****************************************
  // start-source encodings
  // ****************************************
  localparam logic [2:0] SRC_SOFTWARE = 3'h0;
  localparam logic [2:0] SRC_TIMER0 = 3'h1;
  localparam logic [2:0] SRC_TIMER2 = 3'h2;
  localparam logic [2:0] SRC_TIMER1 = 3'h3;
  localparam logic [2:0] SRC_EXT_PIN = 3'h4;
  localparam logic [2:0] SRC_TIMER3 = 3'h5;
  localparam logic [2:0] SRC_TIMER4 = 3'h6;
  localparam logic [2:0] SRC_TIMER5 = 3'h7;
  localparam int TIMER_COUNT = 6;

  // ****************************************
  // timing
  // ****************************************
  localparam int CORE_CLK_KHZ = 40000;
  localparam int SAR_CLK_MAX_KHZ = 8330;
  // fastest conversion clock not above its limit: divide rounds up
  localparam int SAR_DIV = (CORE_CLK_KHZ + SAR_CLK_MAX_KHZ - 1) / SAR_CLK_MAX_KHZ;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] CONV_TICKS_10BIT = 4'hD;
  localparam logic [CNT_W-1:0] CONV_TICKS_8BIT = 4'hB;
  localparam logic [CNT_W-1:0] DELAY_TRACK_TICKS = 4'h3;
  localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_DELAY,
    ST_CONVERT
  } conv_state_t;

endpackage : adc_ctrl_pkg

// ### hw/sar_tick_if.sv
interface sar_tick_if;
  logic run;
  logic tick;
  modport src (input run, output tick);
  modport dst (output run, input tick);
endinterface : sar_tick_if

// ### hw/sar_clk_div.sv
module sar_clk_div #(
  parameter int DIV = adc_ctrl_pkg::SAR_DIV
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // conversion clock enable
  sar_tick_if.src tickPort
);

  typedef struct packed {
    logic [7:0] count;
    logic tick;
  } div_t;

  localparam logic [7:0] DIV_LAST = 8'(DIV - 1);

  div_t cur_r;
  div_t cur_nxt;

  // counter held at zero while stopped so the first tick comes DIV cycles after start
  always_comb begin
    cur_nxt = cur_r;
    cur_nxt.tick = 1'b0;
    if (!tickPort.run) begin
      cur_nxt.count = 8'h00;
    end else if (cur_r.count == DIV_LAST) begin
      cur_nxt.count = 8'h00;
      cur_nxt.tick = 1'b1;
    end else begin
      cur_nxt.count = cur_r.count + 8'h01;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cur_r <= '0;
    end else begin
      cur_r <= cur_nxt;
    end
  end

  assign tickPort.tick = cur_r.tick;

endmodule : sar_clk_div

// ### hw/sar_adc_conversion_control.sv
// Functional notes
// - enable bit 0 keeps converter shut down; 1 makes it active and accepting starts
// - normal tracking: track except while converting, convert at once on start
// - delayed tracking: on start, track three more conversion clocks, then convert
// - external pin start never adds the extra tracking delay
// - writing busy=1 starts a conversion only with source 000; writing 0 does nothing
// - source 001 timer0, 010 timer2, 011 timer1, 100 external pin rising edge
// - source 101 timer3, 110 timer4, 111 timer5 overflow
// - conversion lasts 13 conversion clocks in 10-bit mode, 11 in 8-bit mode
module sar_adc_conversion_control (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // special-function register port
  input wire logic [7:0] sfrAddr,
  input wire logic [7:0] sfrWrData,
  input wire logic sfrWr,
  input wire logic sfrRd,
  output logic [7:0] sfrRdData,
  // start sources
  input wire logic [adc_ctrl_pkg::TIMER_COUNT-1:0] timerOverflow,
  input wire logic external_start_pin,
  // analog core side
  input wire logic eightBitMode,
  input wire logic windowHit,
  output logic converterPowered,
  output logic trackActive,
  output logic convertActive,
  output logic sarStep,
  output logic resultLatch
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    adc_ctrl_pkg::conv_state_t state;
    logic [adc_ctrl_pkg::CNT_W-1:0] cnt;
    logic enable;
    logic trackDelayed;
    logic done;
    logic window;
    logic [2:0] source;
    logic [2:0] extSync;
    logic extLevel;
    logic [7:0] rdData;
    logic powered;
    logic tracking;
    logic converting;
    logic sarStep;
    logic resultLatch;
  } ctrl_t;

  ctrl_t cur_r;
  ctrl_t cur_nxt;
  sar_tick_if tickBus ();

  // ****************************************
  // conversion clock
  // ****************************************
  sar_clk_div #(
    .DIV(adc_ctrl_pkg::SAR_DIV)
  ) u_div (
    .core_clk(core_clk),
    .resetn(resetn),
    .tickPort(tickBus.src)
  );

  // the divider stops in shutdown, saving power between uses
  assign tickBus.run = cur_r.enable;

  // hardware trigger for the selected source; software start is handled apart
  function automatic logic hwTrigger(input logic [2:0] src,
                                     input logic [adc_ctrl_pkg::TIMER_COUNT-1:0] tmr,
                                     input logic extRise);
    logic hit;
    hit = 1'b0;
    unique case (src)
      adc_ctrl_pkg::SRC_SOFTWARE: hit = 1'b0;
      adc_ctrl_pkg::SRC_TIMER0: hit = tmr[0];
      adc_ctrl_pkg::SRC_TIMER2: hit = tmr[2];
      adc_ctrl_pkg::SRC_TIMER1: hit = tmr[1];
      adc_ctrl_pkg::SRC_EXT_PIN: hit = extRise;
      adc_ctrl_pkg::SRC_TIMER3: hit = tmr[3];
      adc_ctrl_pkg::SRC_TIMER4: hit = tmr[4];
      adc_ctrl_pkg::SRC_TIMER5: hit = tmr[5];
    endcase
    return hit;
  endfunction : hwTrigger

  // ****************************************
  // next-state logic
  // ****************************************
  always_comb begin
    logic ctrlWr;
    logic ctrlRd;
    logic extRise;
    logic start;
    logic finish;
    logic [adc_ctrl_pkg::CNT_W-1:0] convLast;
    logic [7:0] regView;
    ctrlWr = 1'b0;
    ctrlRd = 1'b0;
    extRise = 1'b0;
    start = 1'b0;
    finish = 1'b0;
    convLast = adc_ctrl_pkg::CNT_ZERO;
    regView = 8'h00;
    cur_nxt = cur_r;
    cur_nxt.sarStep = 1'b0;
    cur_nxt.resultLatch = 1'b0;
    ctrlWr = sfrWr && (sfrAddr == adc_ctrl_pkg::CTRL_ADDR);
    ctrlRd = sfrRd && (sfrAddr == adc_ctrl_pkg::CTRL_ADDR);

    // three-stage pin sampler; level moves only when stages two and three agree
    cur_nxt.extSync = {cur_r.extSync[1:0], external_start_pin};
    if (cur_r.extSync[1] == cur_r.extSync[2]) begin
      cur_nxt.extLevel = cur_r.extSync[2];
    end
    extRise = cur_nxt.extLevel && !cur_r.extLevel;

    // start request from the current source, taken only when idle and enabled
    start = hwTrigger(cur_r.source, timerOverflow, extRise);
    if (ctrlWr && sfrWrData[adc_ctrl_pkg::BIT_BUSY]
        && (cur_r.source == adc_ctrl_pkg::SRC_SOFTWARE)) begin
      start = 1'b1;
    end
    convLast = (eightBitMode ? adc_ctrl_pkg::CONV_TICKS_8BIT
                             : adc_ctrl_pkg::CONV_TICKS_10BIT) - adc_ctrl_pkg::CNT_ONE;

    // sequencer; a start during a conversion is ignored
    unique case (cur_r.state)
      adc_ctrl_pkg::ST_IDLE: begin
        if (cur_r.enable && start) begin
          cur_nxt.cnt = adc_ctrl_pkg::CNT_ZERO;
          if (cur_r.trackDelayed && (cur_r.source != adc_ctrl_pkg::SRC_EXT_PIN)) begin
            cur_nxt.state = adc_ctrl_pkg::ST_DELAY;
          end else begin
            cur_nxt.state = adc_ctrl_pkg::ST_CONVERT;
          end
        end
      end
      adc_ctrl_pkg::ST_DELAY: begin
        if (tickBus.tick) begin
          if (cur_r.cnt == adc_ctrl_pkg::DELAY_TRACK_TICKS - adc_ctrl_pkg::CNT_ONE) begin
            cur_nxt.cnt = adc_ctrl_pkg::CNT_ZERO;
            cur_nxt.state = adc_ctrl_pkg::ST_CONVERT;
          end else begin
            cur_nxt.cnt = cur_r.cnt + adc_ctrl_pkg::CNT_ONE;
          end
        end
      end
      adc_ctrl_pkg::ST_CONVERT: begin
        if (tickBus.tick) begin
          cur_nxt.sarStep = 1'b1;
          if (cur_r.cnt == convLast) begin
            finish = 1'b1;
            cur_nxt.state = adc_ctrl_pkg::ST_IDLE;
          end else begin
            cur_nxt.cnt = cur_r.cnt + adc_ctrl_pkg::CNT_ONE;
          end
        end
      end
      // the fourth code of the state field is never entered; fall back to idle
      default: begin
        cur_nxt.state = adc_ctrl_pkg::ST_IDLE;
      end
    endcase

    // software writes of the stored fields and the two flags
    if (ctrlWr) begin
      cur_nxt.enable = sfrWrData[adc_ctrl_pkg::BIT_ENABLE];
      cur_nxt.trackDelayed = sfrWrData[adc_ctrl_pkg::BIT_TRACK_MODE];
      cur_nxt.done = sfrWrData[adc_ctrl_pkg::BIT_DONE];
      cur_nxt.window = sfrWrData[adc_ctrl_pkg::BIT_WINDOW];
      cur_nxt.source = sfrWrData[adc_ctrl_pkg::SRC_MSB:adc_ctrl_pkg::SRC_LSB];
    end

    // completion sets flags after the write so an event racing a clear survives
    if (finish) begin
      cur_nxt.done = 1'b1;
      cur_nxt.resultLatch = 1'b1;
      if (windowHit) begin
        cur_nxt.window = 1'b1;
      end
    end

    // shutdown abandons any conversion under way
    if (!cur_nxt.enable) begin
      cur_nxt.sarStep = 1'b0; // no step pulse for a conversion that no longer runs
      cur_nxt.state = adc_ctrl_pkg::ST_IDLE;
      cur_nxt.cnt = adc_ctrl_pkg::CNT_ZERO;
    end

    // pin-facing status, registered from the next state
    cur_nxt.powered = cur_nxt.enable;
    cur_nxt.converting = cur_nxt.state == adc_ctrl_pkg::ST_CONVERT;
    cur_nxt.tracking = cur_nxt.enable && !cur_nxt.converting;

    // read data shows live state; busy is derived, never stored
    regView = {cur_r.enable, cur_r.trackDelayed, cur_r.done,
               cur_r.state != adc_ctrl_pkg::ST_IDLE, cur_r.window, cur_r.source};
    cur_nxt.rdData = ctrlRd ? regView : 8'h00;
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cur_r <= '0;
    end else begin
      cur_r <= cur_nxt;
    end
  end

  // outputs straight from flip-flops
  assign sfrRdData = cur_r.rdData;
  assign converterPowered = cur_r.powered;
  assign trackActive = cur_r.tracking;
  assign convertActive = cur_r.converting;
  assign sarStep = cur_r.sarStep;
  assign resultLatch = cur_r.resultLatch;

endmodule : sar_adc_conversion_control

// ### tb/adc_ctrl_asserts.sv
// ********
// converter control checker
// ********
module adc_ctrl_asserts (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // register port
  input wire logic [7:0] sfrAddr,
  input wire logic [7:0] sfrWrData,
  input wire logic sfrWr,
  input wire logic sfrRd,
  input wire logic [7:0] sfrRdData,
  // start sources
  input wire logic [adc_ctrl_pkg::TIMER_COUNT-1:0] timerOverflow,
  input wire logic external_start_pin,
  // analog core side
  input wire logic eightBitMode,
  input wire logic windowHit,
  input wire logic converterPowered,
  input wire logic trackActive,
  input wire logic convertActive,
  input wire logic sarStep,
  input wire logic resultLatch
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  logic [4:0] stepCnt_r;
  // steps of the running conversion; cleared at completion so a start right after counts afresh
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) stepCnt_r <= 5'h00;
    else if (resultLatch || !convertActive) stepCnt_r <= 5'h00;
    else if (sarStep) stepCnt_r <= stepCnt_r + 5'h01;
  end
  sequence sRegRead;
    sfrRd && sfrAddr == adc_ctrl_pkg::CTRL_ADDR;
  endsequence
  // a read taken on the very edge that sees the completion pulse
  sequence sDoneRead;
    resultLatch ##0 sRegRead;
  endsequence
  AST_SHUTDOWN: assert property (!converterPowered |-> !trackActive && !convertActive)
    else $error("active while shut down");
  AST_DISABLE: assert property (sfrWr && sfrAddr == 8'hE8 && !sfrWrData[7]
    |=> !converterPowered && !convertActive) else $error("disable ignored");
  AST_TRACK: assert property (converterPowered |-> trackActive != convertActive)
    else $error("track and convert overlap");
  AST_FROM_TRACK: assert property ($rose(convertActive) |-> $past(trackActive))
    else $error("conversion without tracking");
  AST_STEP: assert property (sarStep |-> convertActive || resultLatch)
    else $error("step outside conversion");
  AST_LEN: assert property (resultLatch |->
    (stepCnt_r + 5'(sarStep)) == (eightBitMode ? 5'h0B : 5'h0D)) else $error("bad length");
  AST_LATCH: assert property (resultLatch |-> !convertActive && $past(convertActive))
    else $error("completion without conversion");
  AST_BUSY: assert property (convertActive && sfrRd && sfrAddr == 8'hE8
    |=> sfrRdData[4]) else $error("busy reads 0");
  AST_DONE: assert property (sDoneRead |=> sfrRdData[5] && !sfrRdData[4])
    else $error("done flag missing");
  AST_WIN: assert property (resultLatch && $past(windowHit) ##0 sRegRead
    |=> sfrRdData[3]) else $error("window flag missing");
endmodule : adc_ctrl_asserts

bind sar_adc_conversion_control adc_ctrl_asserts u_adc_ctrl_asserts (.core_clk, .resetn,
  .sfrAddr, .sfrWrData, .sfrWr, .sfrRd, .sfrRdData, .timerOverflow, .external_start_pin,
  .eightBitMode, .windowHit, .converterPowered, .trackActive, .convertActive, .sarStep,
  .resultLatch);

// ### tb/start_src_model.sv
// ********
// timer overflows and external start pin
// ********
module start_src_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // request from the bench
  input wire logic go,
  input wire logic [2:0] src,
  // start events
  output logic [adc_ctrl_pkg::TIMER_COUNT-1:0] timerOverflow,
  output logic external_start_pin
);
  timeunit 1ns;
  timeprecision 100ps;
  int tIdx[8] = '{0, 0, 2, 1, 0, 3, 4, 5};
  int pinHold;
  assign external_start_pin = (pinHold > 0);
  // overflow is a one-cycle pulse; the pin stays high a random while
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      timerOverflow <= '0;
      pinHold <= 0;
    end else begin
      timerOverflow <= '0;
      if (pinHold > 0) pinHold <= pinHold - 1;
      if (go && src == 3'h4) pinHold <= 3 + $urandom_range(6);
      else if (go && src != 3'h0) timerOverflow[tIdx[src]] <= 1'b1;
    end
  end
endmodule : start_src_model

// ### tb/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] sfrAddr = 8'h00;
  logic [7:0] sfrWrData = 8'h00;
  logic sfrWr = 1'b0;
  logic sfrRd = 1'b0;
  logic eightBitMode = 1'b0;
  logic windowHit = 1'b0;
  logic go = 1'b0;
  logic [2:0] src = 3'h0;
  logic [7:0] sfrRdData, got;
  logic [adc_ctrl_pkg::TIMER_COUNT-1:0] timerOverflow;
  logic external_start_pin, converterPowered, trackActive, convertActive, sarStep, resultLatch;
  logic convSeen = 1'b0;
  int nFail = 0;
  int testsRun = 0;
  int mDone = 0;
  int mWin = 0;
  int lenQ[$];

  always #12.5 core_clk = ~core_clk;
  always @(posedge core_clk) if (convertActive) convSeen <= 1'b1;

  sar_adc_conversion_control u_sar_adc_conversion_control (.core_clk, .resetn, .sfrAddr,
    .sfrWrData, .sfrWr, .sfrRd, .sfrRdData, .timerOverflow, .external_start_pin, .eightBitMode,
    .windowHit, .converterPowered, .trackActive, .convertActive, .sarStep, .resultLatch);
  start_src_model u_start_src_model (.core_clk, .resetn, .go, .src, .timerOverflow,
    .external_start_pin);

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    testsRun++;
    if (seen !== exp) begin
      nFail++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic tk(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    tk(1);
    sfrAddr = a;
    sfrWrData = d;
    sfrWr = 1'b1;
    tk(1);
    sfrWr = 1'b0;
  endtask : wr
  // starts at once so a read can land on the edge that sees the completion
  task automatic rd(input logic [7:0] a);
    sfrAddr = a;
    sfrRd = 1'b1;
    tk(1);
    sfrRd = 1'b0;
    got = sfrRdData;
  endtask : rd
  task automatic pulse(input int s);
    src = 3'(s);
    go = 1'b1;
    tk(1);
    go = 1'b0;
  endtask : pulse
  function automatic logic [7:0] mreg(input int en, input int dm, input int s);
    return {en[0], dm[0], mDone[0], 1'b0, mWin[0], s[2:0]};
  endfunction : mreg
  // one conversion from the given source, then latency, length and flags
  task automatic conv(input int s, input int dm);
    int lat;
    int steps;
    lat = 0;
    eightBitMode = 1'($urandom);
    windowHit = 1'($urandom);
    lenQ.push_back(eightBitMode ? 11 : 13);
    wr(8'hE8, mreg(1, dm, s));
    if (s == 0) wr(8'hE8, mreg(1, dm, s) | 8'h10);
    else pulse(s);
    while (!convertActive && lat < 200) begin
      tk(1);
      lat++;
    end
    chk(8'(lat >= 10), 8'(dm == 1 && s != 4));
    chk(8'(trackActive), 8'h00);
    steps = sarStep;
    while (!resultLatch && lat < 400) begin
      tk(1);
      lat++;
      steps += sarStep;
    end
    chk(8'(lat < 400), 8'h01);
    chk(8'(steps), 8'(lenQ.pop_front()));
    chk(8'(trackActive), 8'h01);
    mDone = 1;
    if (windowHit) mWin = 1;
    rd(8'hE8);
    chk(got, mreg(1, dm, s));
    if ($urandom_range(1) == 1) begin
      mDone = 0;
      mWin = 0;
      wr(8'hE8, mreg(1, dm, s));
      rd(8'hE8);
      chk(got, mreg(1, dm, s));
    end
  endtask : conv
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", testsRun, nFail);
    if (nFail == 0 && testsRun > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish

  // ********
  // main sequence
  // ********
  initial begin
    void'($urandom(32'hE760));
    tk(4);
    resetn = 1'b1;
    rd(8'hE8);
    chk(got, 8'h00);
    chk(8'(converterPowered), 8'h00);
    chk(8'(trackActive), 8'h00);
    wr(8'h55, 8'hFF);
    rd(8'h55);
    chk(got, 8'h00);
    $display("reset and unmapped test done");
    for (int i = 0; i < 16; i++) begin
      conv(i % 8, i / 8);
      $display("source test %0d done", i);
    end
    // dropped starts: busy under a timer source, unselected timer, shut down
    convSeen = 1'b0;
    wr(8'hE8, 8'h91);
    pulse(5);
    wr(8'hE8, 8'h80);
    wr(8'hE8, 8'h00);
    wr(8'hE8, 8'h10);
    wr(8'hE8, 8'h04);
    pulse(4);
    tk(20);
    chk(8'(convSeen), 8'h00);
    $display("refusal test done");
    // busy reads 1 mid-conversion; a disable then leaves no done flag
    wr(8'hE8, 8'h80);
    wr(8'hE8, 8'h90);
    tk(8);
    rd(8'hE8);
    chk(got, 8'h90);
    wr(8'hE8, 8'h00);
    rd(8'hE8);
    chk(got, 8'h00);
    $display("abort test done");
    tally_and_finish();
  end

  // watchdog far beyond the expected run of under two thousand cycles
  initial begin
    #500000;
    nFail++;
    tally_and_finish();
  end
endmodule : tb
